// ===== tawp_checker_assertions.sv
// port-level checker of the table access block
// assumes one clock and the bench's avalon master
`timescale 1ns/1ps
`include "tawp_defs.vh"
module tawp_checker #(
  parameter PTR_W = 6
) (
  input wire        clock_in,
  input wire        rst_n_in,
  input wire [7:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        master_clear_pin_pin_in,
  input wire        master_clear_pin_reset_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire req = avs_read_in | avs_write_in;
  wire rd_ack = avs_read_in & !avs_waitrequest_out;
  // ==========================================================
  // bus
  ack_bounded_a: assert property (req && avs_waitrequest_out |-> ##[1:16] !avs_waitrequest_out)
    else $error("request not acknowledged");
  first_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
    else $error("read acknowledged too early");
  idle_no_wait_a: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait without request");
  data_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (rd_ack && avs_address_in > `TAWP_ADDR_WDATA
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  // ==========================================================
  // protection word and pin
  prot_ones_a: assert property (rd_ack && avs_address_in == `TAWP_ADDR_PROT |->
    (avs_readdata_out[7:0] & `TAWP_PROT_ONES) == `TAWP_PROT_ONES)
    else $error("unused protection bits not one");
  pin_idle_a: assert property (master_clear_pin_pin_in [*5] |=> !master_clear_pin_reset_out)
    else $error("reset request with pin high");
  pin_cause_a: assert property ($rose(master_clear_pin_reset_out) |->
    !$past(master_clear_pin_pin_in, 2) || !$past(master_clear_pin_pin_in, 3) || !$past(master_clear_pin_pin_in, 4))
    else $error("reset request without pin low");
endmodule // tawp_checker

// ===== tawp_core_model.sv
// processor core model: issues table operations as avalon transfers
// assumes a slave that lowers waitrequest within 64 cycles
`timescale 1ns/1ps
module tawp_core_model (
  // clock
  input  wire        clock_in,
  // avalon master
  output reg  [7:0]  address_out,
  output reg         read_out,
  output reg         write_out,
  output reg  [31:0] writedata_out,
  input  wire [31:0] readdata_in,
  input  wire        waitrequest_in
);
  reg hung = 1'b0;
  initial begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0;
  end
  // request held until the rising edge that sees waitrequest low
  task bus(input wr, input [7:0] a, input [31:0] d, output [31:0] q);
    integer i;
    begin
      @(posedge clock_in);
      address_out <= a;
      read_out <= !wr;
      write_out <= wr;
      writedata_out <= d;
      i = 0;
      @(posedge clock_in);
      while (waitrequest_in && i < 64) begin
        @(posedge clock_in);
        i = i + 1;
      end
      q = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      if (i >= 64) hung = 1'b1;
    end
  endtask
endmodule // tawp_core_model

// ===== tawp_defs.vh
// constants of the table access and write protect block
// assumes a 32-bit avalon slave with word-aligned registers
`ifndef TAWP_DEFS_VH
`define TAWP_DEFS_VH

// ==========================================================
// register byte addresses
`define TAWP_ADDR_CTRL      8'h00
`define TAWP_ADDR_PTR       8'h04
`define TAWP_ADDR_CMD       8'h08
`define TAWP_ADDR_RDATA     8'h0c
`define TAWP_ADDR_PROT      8'h10
`define TAWP_ADDR_STATUS    8'h14
`define TAWP_ADDR_WDATA     8'h18
// printed location of the protection word
`define TAWP_PROT_LOCATION  24'h300007

// ==========================================================
// protection word fields
`define TAWP_BIT_BOOT       0
`define TAWP_BIT_CONFIG     1
`define TAWP_BIT_EEPROM     2
`define TAWP_BIT_FLASH      3
`define TAWP_BIT_LVP        5
`define TAWP_PROT_RESET     8'hff
`define TAWP_PROT_ONES      8'hd0

// ==========================================================
// command fields: [2:0] mode, [3] write, [5:4] region
`define TAWP_MODE_PLAIN     3'h1
`define TAWP_MODE_POSTINC   3'h2
`define TAWP_MODE_POSTDEC   3'h4
`define TAWP_MODE_PREINC    3'h0
`define TAWP_REG_FLASH      2'h0
`define TAWP_REG_EEPROM     2'h1
`define TAWP_REG_CONFIG     2'h2
`define TAWP_REG_BOOT       2'h3

`endif

// ===== tawp_mem.v
// small program memory for table access
// assumes one clock; read data are registered
`timescale 1ns/1ps
module tawp_mem #(
  parameter AW = 6,
  parameter DW = 8
) (
  // clock
  input  wire          clock_in,
  // access
  input  wire [AW-1:0] addr_in,
  input  wire          wr_en_in,
  input  wire [DW-1:0] wr_data_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] store [0:(1<<AW)-1];

  always @(posedge clock_in) begin
    if (wr_en_in) begin
      store[addr_in] <= wr_data_in;
    end
    rd_data_out <= store[addr_in];
  end
endmodule // tawp_mem

// ===== tawp_prot.v
// protection configuration word
// assumes bulk erase and programming mode come from same-clock logic
`timescale 1ns/1ps
`include "tawp_defs.vh"
module tawp_prot (
  // clock and reset
  input  wire       clock_in,
  input  wire       rst_n_in,
  // control
  input  wire       wr_in,
  input  wire [7:0] wr_data_in,
  input  wire       bulk_erase_in,
  input  wire       lvp_active_in,
  // state
  output wire [7:0] prot_out
);
  reg [7:0] word;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word <= `TAWP_PROT_RESET;
    end else if (bulk_erase_in) begin
      word <= `TAWP_PROT_RESET;
    end else if (wr_in && word[`TAWP_BIT_CONFIG]) begin
      // protect bits only go from one to zero
      word[3:0] <= word[3:0] & wr_data_in[3:0];
      if (!lvp_active_in) begin
        word[`TAWP_BIT_LVP] <= wr_data_in[`TAWP_BIT_LVP];
      end
    end
  end

  assign prot_out = word | `TAWP_PROT_ONES;
endmodule // tawp_prot

// ===== tawp_top.v
// table pointer access engine with write protection, avalon slave
// assumes a single 250 MHz clock and a same-clock avalon master
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "tawp_defs.vh"
module tawp_top #(
  parameter PTR_W = 6
) (
  // clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // avalon slave
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // pins and programming state
  input  wire        master_clear_pin_pin_in,
  input  wire        lvp_active_in,
  input  wire        bulk_erase_in,
  // reset request from the master clear pin
  output reg         master_clear_pin_reset_out
);
  // ==========================================================
  // pin synchroniser
  reg master_clear_pin_meta;
  reg master_clear_pin_sync;
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_clear_pin_meta <= 1'b1;
      master_clear_pin_sync <= 1'b1;
    end else begin
      master_clear_pin_meta <= master_clear_pin_pin_in;
      master_clear_pin_sync <= master_clear_pin_meta;
    end
  end

  // ==========================================================
  // state machine
  localparam S_IDLE = 4'h1;
  localparam S_PRE  = 4'h2;
  localparam S_ACC  = 4'h4;
  localparam S_DONE = 4'h8;

  reg  [3:0]       state;
  reg  [PTR_W-1:0] table_pointer;
  reg  [5:0]       cmd;
  reg  [7:0]       wdata;
  reg  [7:0]       rdata;
  reg              master_clear_pin_pin_enable;
  reg              dropped;
  reg              ack;
  wire [7:0]       prot;
  wire [7:0]       mem_q;

  function [PTR_W-1:0] step;
    input [PTR_W-1:0] p;
    input [2:0]       mode;
    begin
      if (mode == `TAWP_MODE_POSTINC || mode == `TAWP_MODE_PREINC) begin
        step = p + 1'b1;
      end else if (mode == `TAWP_MODE_POSTDEC) begin
        step = p - 1'b1;
      end else begin
        step = p;
      end
    end
  endfunction

  function allowed;
    input [1:0] region;
    input [7:0] pw;
    begin
      if (region == `TAWP_REG_FLASH) begin
        allowed = pw[`TAWP_BIT_FLASH];
      end else if (region == `TAWP_REG_EEPROM) begin
        allowed = pw[`TAWP_BIT_EEPROM];
      end else if (region == `TAWP_REG_CONFIG) begin
        allowed = pw[`TAWP_BIT_CONFIG];
      end else begin
        allowed = pw[`TAWP_BIT_BOOT];
      end
    end
  endfunction

  wire is_write = cmd[3];
  wire ok_write = is_write && allowed(cmd[5:4], prot);
  wire mem_we   = (state == S_ACC) && ok_write;
  wire busy     = (state != S_IDLE);

  // ==========================================================
  // address decode
  wire sel_ctrl   = (avs_address_in == `TAWP_ADDR_CTRL);
  wire sel_ptr    = (avs_address_in == `TAWP_ADDR_PTR);
  wire sel_cmd    = (avs_address_in == `TAWP_ADDR_CMD);
  wire sel_rdata  = (avs_address_in == `TAWP_ADDR_RDATA);
  wire sel_prot   = (avs_address_in == `TAWP_ADDR_PROT);
  wire sel_status = (avs_address_in == `TAWP_ADDR_STATUS);
  wire sel_wdata  = (avs_address_in == `TAWP_ADDR_WDATA);

  // ==========================================================
  // bus handshake
  wire hit_cmd   = avs_write_in && sel_cmd;
  // a write lands on the edge that sees waitrequest low, never earlier
  wire wr_commit = avs_write_in && ack;
  // read data are captured one edge ahead so they stand at that edge
  wire rd_launch = avs_read_in && !ack;
  wire hit_prot  = wr_commit && sel_prot && !busy;
  wire take_cmd  = wr_commit && sel_cmd && !busy;

  // a command arriving while busy waits; others answer next cycle
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack <= 1'b0;
    end else if (ack) begin
      ack <= 1'b0;
    end else if (avs_read_in || (avs_write_in && !(hit_cmd && busy))) begin
      ack <= 1'b1;
    end
  end

  // ==========================================================
  // control register
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_clear_pin_pin_enable <= 1'b1;
    end else if (wr_commit && sel_ctrl) begin
      master_clear_pin_pin_enable <= avs_writedata_in[0];
    end
  end

  // ==========================================================
  // write data register
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdata <= 8'h00;
    end else if (wr_commit && sel_wdata) begin
      wdata <= avs_writedata_in[7:0];
    end
  end

  // ==========================================================
  // command register
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd <= 6'h00;
    end else if (take_cmd) begin
      cmd <= avs_writedata_in[5:0];
    end
  end

  // ==========================================================
  // table pointer
  // software may only load it while idle, so engine steps never collide
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      table_pointer <= {PTR_W{1'b0}};
    end else if (state == S_PRE) begin
      table_pointer <= table_pointer + 1'b1;
    end else if (state == S_ACC) begin
      // pre-increment already stepped; post-increment and post-decrement step after access, plain holds
      if (cmd[2:0] != `TAWP_MODE_PREINC) begin
        table_pointer <= step(table_pointer, cmd[2:0]);
      end
    end else if (wr_commit && sel_ptr && !busy) begin
      table_pointer <= avs_writedata_in[PTR_W-1:0];
    end
  end

  // ==========================================================
  // access sequencer
  reg [3:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take_cmd) begin
          next_state = (avs_writedata_in[2:0] == `TAWP_MODE_PREINC) ? S_PRE : S_ACC;
        end
      end
      S_PRE: begin
        next_state = S_ACC;
      end
      S_ACC: begin
        next_state = S_DONE;
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // dropped-write flag, refreshed by every access
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dropped <= 1'b0;
    end else if (state == S_ACC) begin
      dropped <= is_write && !ok_write;
    end
  end

  // ==========================================================
  // table read result
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= 8'h00;
    end else if (state == S_DONE && !is_write) begin
      rdata <= mem_q;
    end
  end

  // ==========================================================
  // master clear pin handling
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_clear_pin_reset_out <= 1'b0;
    end else begin
      // lvp forces reset function regardless of pin enable
      master_clear_pin_reset_out <= (prot[`TAWP_BIT_LVP] || master_clear_pin_pin_enable) && !master_clear_pin_sync;
    end
  end

  // ==========================================================
  // read mux
  reg [31:0] next_readdata;

  always @* begin
    next_readdata = 32'h00000000;
    if (sel_ctrl) begin
      next_readdata = {31'h00000000, master_clear_pin_pin_enable};
    end else if (sel_ptr) begin
      next_readdata = {{(32-PTR_W){1'b0}}, table_pointer};
    end else if (sel_cmd) begin
      next_readdata = {26'h0000000, cmd};
    end else if (sel_rdata) begin
      next_readdata = {24'h000000, rdata};
    end else if (sel_prot) begin
      next_readdata = {24'h000000, prot};
    end else if (sel_status) begin
      next_readdata = {29'h00000000, master_clear_pin_reset_out, dropped, busy};
    end else if (sel_wdata) begin
      next_readdata = {24'h000000, wdata};
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (rd_launch) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ==========================================================
  // submodules
  tawp_prot u_prot (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .wr_in         (hit_prot),
    .wr_data_in    (avs_writedata_in[7:0]),
    .bulk_erase_in (bulk_erase_in),
    .lvp_active_in (lvp_active_in),
    .prot_out      (prot)
  );

  tawp_mem #(.AW(PTR_W), .DW(8)) u_mem (
    .clock_in    (clock_in),
    .addr_in     (table_pointer),
    .wr_en_in    (mem_we),
    .wr_data_in  (wdata),
    .rd_data_out (mem_q)
  );
endmodule // tawp_top

// ===== tb_top.sv
// self-checking bench of the table access block
// assumes the core model as sole bus master
`timescale 1ns/1ps
`include "tawp_defs.vh"
module tb_top;
  reg         clock_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         pin = 1'b1;
  reg         low_voltage_program_enable = 1'b0;
  reg         erase = 1'b0;
  wire [7:0]  addr;
  wire        rd, wr, wait_r, mrst;
  wire [31:0] wdat, rdat;
  reg  [31:0] q;
  integer     n_fail = 0, n_tests = 0, k, b;
  always #2 clock_in = ~clock_in;
  tawp_top #(.PTR_W(6)) tawp_top_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .master_clear_pin_pin_in(pin),
    .lvp_active_in(low_voltage_program_enable), .bulk_erase_in(erase), .master_clear_pin_reset_out(mrst));
  tawp_core_model tawp_core_model_i (.clock_in(clock_in), .address_out(addr),
    .read_out(rd), .write_out(wr), .writedata_out(wdat), .readdata_in(rdat),
    .waitrequest_in(wait_r));
  // ==========================================================
  // helpers
  task end_of_test;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      tawp_core_model_i.bus(w, a, d, q);
      if (tawp_core_model_i.hung) begin
        n_fail = n_fail + 1;
        end_of_test;
      end
    end
  endtask
  // command, then poll busy; the engine needs only a few cycles
  task op(input [7:0] c);
    integer i;
    begin
      xfer(1, `TAWP_ADDR_CMD, {24'h0, c});
      i = 0;
      do begin
        xfer(0, `TAWP_ADDR_STATUS, 0);
        i = i + 1;
      end while (q[0] !== 1'b0 && i < 16);
      check(q[0], 0);
      if (q[0] !== 1'b0) end_of_test;
    end
  endtask
  task store(input [7:0] p, input [7:0] d, input [7:0] c);
    begin
      xfer(1, `TAWP_ADDR_WDATA, {24'h0, d});
      xfer(1, `TAWP_ADDR_PTR, {24'h0, p});
      op(c);
    end
  endtask
  task bulk;
    begin
      @(posedge clock_in) erase <= 1'b1;
      @(posedge clock_in) erase <= 1'b0;
    end
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    xfer(0, `TAWP_ADDR_PROT, 0);
    check(q[7:0], `TAWP_PROT_RESET);
    xfer(0, 8'h1c, 0);
    check(q, 0);
    store(8'd9, 8'h3c, 8'h09);
    store(8'd10, 8'h5a, 8'h09);
    check(q[1], 0);
    for (k = 0; k < 4; k = k + 1) begin
      xfer(1, `TAWP_ADDR_PTR, 9);
      op(k == 3 ? {5'h0, `TAWP_MODE_PREINC} : 8'h1 << k);
      xfer(0, `TAWP_ADDR_PTR, 0);
      check(q[5:0], k == 0 ? 9 : k == 2 ? 8 : 10);
      xfer(0, `TAWP_ADDR_RDATA, 0);
      check(q[7:0], k == 3 ? 8'h5a : 8'h3c);
    end
    for (k = 0; k < 2; k = k + 1) begin
      b = `TAWP_BIT_FLASH - k;
      xfer(1, `TAWP_ADDR_PROT, 8'hff ^ (8'h1 << b));
      store(8'd9, 8'h11, {2'h0, k[1:0], 4'h9});
      check(q[1], 1);
      xfer(1, `TAWP_ADDR_PROT, 8'hff);
      xfer(0, `TAWP_ADDR_PROT, 0);
      check(q[7:0], 8'hff ^ (8'h1 << b));
      bulk;
      xfer(0, `TAWP_ADDR_PROT, 0);
      check(q[7:0], 8'hff);
    end
    op(8'h01);
    check(q[1], 0);
    xfer(0, `TAWP_ADDR_RDATA, 0);
    check(q[7:0], 8'h3c);
    xfer(1, `TAWP_ADDR_PROT, 8'hfd);
    xfer(1, `TAWP_ADDR_PROT, 8'hf7);
    xfer(0, `TAWP_ADDR_PROT, 0);
    check(q[7:0], 8'hfd);
    bulk;
    @(posedge clock_in) low_voltage_program_enable <= 1'b1;
    xfer(1, `TAWP_ADDR_PROT, 8'hdf);
    xfer(0, `TAWP_ADDR_PROT, 0);
    check(q[7:0], 8'hff);
    @(posedge clock_in) low_voltage_program_enable <= 1'b0;
    xfer(1, `TAWP_ADDR_CTRL, 0);
    @(posedge clock_in) pin <= 1'b0;
    k = 0;
    while (mrst !== 1'b1 && k < 8) begin
      @(posedge clock_in);
      k = k + 1;
    end
    check(mrst, 1);
    if (mrst !== 1'b1) end_of_test;
    @(posedge clock_in) pin <= 1'b1;
    repeat (8) @(posedge clock_in);
    check(mrst, 0);
    end_of_test;
  end
endmodule // tb_top

bind tawp_top tawp_checker #(.PTR_W(PTR_W)) tawp_checker_i (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .master_clear_pin_pin_in(master_clear_pin_pin_in),
  .master_clear_pin_reset_out(master_clear_pin_reset_out));
